// *** bms_pkg.sv ***
// bms_pkg: register indices, field positions and command layout for the
// master port status and sniffer register bank.
// assumes a single system clock shared by the bank and the master port logic.
package bms_pkg;

   // register word indices, byte address is four times the index
   localparam logic [9:0] IDX_CAP_ADDR_HI  = 10'h056;  // failed command, upper address
   localparam logic [9:0] IDX_CAP_ADDR_LO  = 10'h057;  // failed command, lower address
   localparam logic [9:0] IDX_CAP_STATUS   = 10'h058;  // failed command qualifiers
   localparam logic [9:0] IDX_MISC_STATUS  = 10'h059;  // master_misc_status
   localparam logic [9:0] IDX_BUS_ERR      = 10'h05A;  // master_bus_error_status
   localparam logic [9:0] IDX_SM_STATE     = 10'h05B;  // master_state_machine_state
   localparam logic [9:0] IDX_MISC_CTRL    = 10'h05C;  // master_misc_control
   localparam logic [9:0] IDX_SNIFF_MATCH  = 10'h05D;  // command_sniffer_match
   localparam logic [9:0] IDX_SNIFF_ADDR   = 10'h05E;  // command_sniffer_address

   localparam int          ADDR_W = 12;     // byte address width of the slave
   localparam int          NQ     = 7;      // number of internal queues
   localparam int          NREQ   = 13;     // bus error requesters
   localparam logic [1:0]  RESP_OKAY   = 2'h0;
   localparam logic [1:0]  RESP_DECERR = 2'h3;

   // misc status fields
   localparam int          ST_POST_ERR  = 0;    // posting_config_error
   localparam int          ST_ETERM_ERR = 1;    // early_term_config_error
   localparam int          ST_Q_LSB     = 18;   // first queue overflow flag
   localparam logic [31:0] ST_MASK      = 32'hFFFC_0003;

   // bus error status fields
   localparam int          BE_LSB  = 19;        // port0_dma_bus_error
   localparam logic [31:0] BE_MASK = 32'hFFF8_0000;

   // misc control fields
   localparam int          CT_FLUSH_LSB = 1;    // flush mode, two bits
   localparam int          CT_QRST_LSB  = 25;   // read_data_queue_reset
   localparam logic [1:0]  FLUSH_AUTO   = 2'h0;
   localparam logic [1:0]  FLUSH_NONE   = 2'h3;

   // sniffer match fields
   localparam int          SN_ENABLE   = 0;
   localparam int          SN_SIZE     = 4;     // four bits
   localparam int          SN_RNW      = 8;
   localparam int          SN_MID      = 9;     // three bits
   localparam int          SN_SRC      = 12;    // source_is_slave_port
   localparam int          SN_FMID     = 14;    // fabric_master_id, two bits
   localparam int          SN_SSIZE    = 16;    // two bits
   localparam int          SN_SIZE_EN  = 25;
   localparam int          SN_RNW_EN   = 26;
   localparam int          SN_MID_EN   = 27;
   localparam int          SN_SRC_EN   = 28;
   localparam int          SN_FMID_EN  = 29;
   localparam int          SN_SSIZE_EN = 30;
   localparam int          SN_ADDR_EN  = 31;
   localparam logic [31:0] SN_MASK     = 32'hFE03_DFF1;

   // capture status fields
   localparam int          CP_VLD   = 0;
   localparam int          CP_LOCK  = 1;
   localparam int          CP_SRC   = 2;
   localparam int          CP_MID   = 3;        // three bits
   localparam int          CP_SSIZE = 6;        // two bits
   localparam int          CP_TYPE  = 8;        // three bits
   localparam int          CP_RNW   = 11;
   localparam int          CP_SIZE  = 12;       // four bits
   localparam int          CP_BE    = 16;       // sixteen bits
   localparam int          CP_UADDR = 28;       // upper four address bits

   // one outgoing command as seen on the master port
   typedef struct packed {
      logic [35:0] addr;            // full command address
      logic [15:0] be;              // byte enables
      logic [3:0]  size;            // transfer size code
      logic [2:0]  xtype;           // transfer type
      logic [2:0]  mid;             // requester id 0..4
      logic [1:0]  fabric_mid;      // fabric_master_id
      logic [1:0]  ssize;           // slave size
      logic        rnw;             // 1 read, 0 write
      logic        src_slave_port;  // source_is_slave_port
      logic        lock_err;        // lock error seen
      logic        line_or_burst;   // not a single transfer
   } bms_cmd_t;

endpackage : bms_pkg

// *** bms_master_status.sv ***
// bms_master_status: status, error, control and command sniffer registers of the
// outbound master port, reached over an AXI4-Lite slave.
// assumes every event input is a same-clock signal from the master port logic.
//
// Chosen here: the AXI4-Lite slave port.
`timescale 1ns/1ps
module bms_master_status
   import bms_pkg::*;
(
   // clock and reset
   input  wire logic              aclk,
   input  wire logic              aresetn,
   // axi4-lite write address
   input  wire logic [ADDR_W-1:0] s_axi_awaddr,
   input  wire logic              s_axi_awvalid,
   output logic                   s_axi_awready,
   // axi4-lite write data
   input  wire logic [31:0]       s_axi_wdata,
   input  wire logic [3:0]        s_axi_wstrb,
   input  wire logic              s_axi_wvalid,
   output logic                   s_axi_wready,
   // axi4-lite write response
   output logic [1:0]             s_axi_bresp,
   output logic                   s_axi_bvalid,
   input  wire logic              s_axi_bready,
   // axi4-lite read address
   input  wire logic [ADDR_W-1:0] s_axi_araddr,
   input  wire logic              s_axi_arvalid,
   output logic                   s_axi_arready,
   // axi4-lite read data
   output logic [31:0]            s_axi_rdata,
   output logic [1:0]             s_axi_rresp,
   output logic                   s_axi_rvalid,
   input  wire logic              s_axi_rready,
   // master port configuration
   input  wire logic              write_posting_enable,
   input  wire logic              early_term_enable,
   input  wire logic              capture_hold_when_valid,
   // outgoing command stream
   input  wire logic              cmd_valid,
   input  wire bms_cmd_t          cmd,
   // failed transaction report
   input  wire logic              fail_valid,
   input  wire bms_cmd_t          fail_cmd,
   // master port events
   input  wire logic              early_term_seen,
   input  wire logic [NQ-1:0]     queue_overflow,
   input  wire logic [NQ-1:0]     queue_underflow,
   input  wire logic              slave_bus_irq,
   input  wire logic              slave_wr_err,
   input  wire logic [3:0]        slave_wr_err_req,
   // outputs to the master port and interrupt collector
   output logic [NQ-1:0]          queue_reset,
   output logic [1:0]             flush_mode,
   output logic                   auto_flush_en,
   output logic                   int_config_error,
   output logic                   int_queue_error
);

   // byte strobes widened to a bit mask
   function automatic logic [31:0] strb_mask(input logic [3:0] s);
      strb_mask = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
   endfunction

   // word index of a byte address
   function automatic logic [9:0] word_idx(input logic [ADDR_W-1:0] a);
      word_idx = a[ADDR_W-1:2];
   endfunction

   // registers that answer on the bus
   function automatic logic mapped(input logic [9:0] i);
      mapped = (i >= IDX_CAP_ADDR_HI) && (i <= IDX_SNIFF_ADDR);
   endfunction

   // axi handshake state
   logic              aw_held_r;      // write address taken, waiting for data
   logic              w_held_r;       // write data taken, waiting for address
   logic [9:0]        wr_idx_r;       // latched write word index
   logic [31:0]       wdata_r;        // latched write data
   logic [3:0]        wstrb_r;        // latched strobes
   logic              aw_held_nxt;
   logic              w_held_nxt;
   logic              bvalid_nxt;
   logic              rvalid_nxt;
   logic              do_write;       // both halves present, perform the write
   logic [31:0]       wbits;          // written ones under the strobes
   logic [31:0]       rd_val;         // read mux result

   // register state
   logic [31:0]       misc_st_r;      // sticky error flags
   logic [31:0]       misc_st_nxt;
   logic [31:0]       bus_err_r;      // posted write error flags
   logic [31:0]       bus_err_nxt;
   logic [1:0]        flush_r;        // flush mode field
   logic [31:0]       sniff_r;        // sniffer criteria
   logic [31:0]       sniffa_r;       // sniffer address
   logic [31:0]       cap_hi_r;       // captured upper address
   logic [31:0]       cap_lo_r;       // captured lower address
   logic [31:0]       cap_st_r;       // captured qualifiers
   logic [31:0]       st_set;         // hardware set terms for misc status
   logic [31:0]       be_set;         // hardware set terms for bus errors
   logic              sniff_hit;      // a command matches the sniffer
   logic              cap_clr;        // software clears the capture set
   logic              cap_take;       // capture event this cycle
   bms_cmd_t          cap_src;        // command to be captured

   // write channel: address and data taken in either order
   always_comb begin
      do_write    = aw_held_r && w_held_r && !s_axi_bvalid;
      aw_held_nxt = aw_held_r || (s_axi_awvalid && s_axi_awready);
      w_held_nxt  = w_held_r || (s_axi_wvalid && s_axi_wready);
      if (do_write) begin
         aw_held_nxt = 1'b0;
         w_held_nxt  = 1'b0;
      end
      bvalid_nxt = do_write || (s_axi_bvalid && !s_axi_bready);
      wbits      = wdata_r & strb_mask(wstrb_r);
   end

   // write channel registers; ready drops once a half is held
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held_r     <= 1'b0;
         w_held_r      <= 1'b0;
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= RESP_OKAY;
         wr_idx_r      <= '0;
         wdata_r       <= '0;
         wstrb_r       <= '0;
      end else begin
         aw_held_r     <= aw_held_nxt;
         w_held_r      <= w_held_nxt;
         s_axi_awready <= !aw_held_nxt && !bvalid_nxt;
         s_axi_wready  <= !w_held_nxt && !bvalid_nxt;
         s_axi_bvalid  <= bvalid_nxt;
         if (s_axi_awvalid && s_axi_awready) begin
            wr_idx_r <= word_idx(s_axi_awaddr);
         end
         if (s_axi_wvalid && s_axi_wready) begin
            wdata_r <= s_axi_wdata;
            wstrb_r <= s_axi_wstrb;
         end
         if (do_write) begin
            s_axi_bresp <= mapped(wr_idx_r) ? RESP_OKAY : RESP_DECERR;
         end
      end
   end

   // read mux; the live slave irq overrides the stored error bits
   always_comb begin
      rd_val = '0;
      unique case (word_idx(s_axi_araddr))
         IDX_CAP_ADDR_HI: rd_val = cap_hi_r;
         IDX_CAP_ADDR_LO: rd_val = cap_lo_r;
         IDX_CAP_STATUS:  rd_val = cap_st_r;
         IDX_MISC_STATUS: rd_val = misc_st_r;
         IDX_BUS_ERR:     rd_val = slave_bus_irq ? BE_MASK : bus_err_r;
         IDX_SM_STATE:    rd_val = '0;
         IDX_MISC_CTRL:   rd_val = {29'h0, flush_r, 1'b0};
         IDX_SNIFF_MATCH: rd_val = sniff_r;
         IDX_SNIFF_ADDR:  rd_val = sniffa_r;
         default:         rd_val = '0;
      endcase
      rvalid_nxt = (s_axi_arvalid && s_axi_arready) || (s_axi_rvalid && !s_axi_rready);
   end

   // read channel; one read under way at a time, no read side effects
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= '0;
         s_axi_rresp   <= RESP_OKAY;
      end else begin
         s_axi_arready <= !rvalid_nxt;
         s_axi_rvalid  <= rvalid_nxt;
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rdata <= rd_val;
            s_axi_rresp <= mapped(word_idx(s_axi_araddr)) ? RESP_OKAY : RESP_DECERR;
         end
      end
   end

   // misc status: hardware set wins over a one written in the same cycle
   always_comb begin
      st_set = '0;
      st_set[ST_POST_ERR]  = cmd_valid && cmd.line_or_burst && !write_posting_enable;
      st_set[ST_ETERM_ERR] = early_term_seen && !early_term_enable;
      for (int q = 0; q < NQ; q++) begin
         st_set[ST_Q_LSB + 2*q]     = queue_overflow[q];
         st_set[ST_Q_LSB + 2*q + 1] = queue_underflow[q];
      end
      misc_st_nxt = misc_st_r;
      if (do_write && (wr_idx_r == IDX_MISC_STATUS)) begin
         misc_st_nxt = misc_st_r & ~wbits;
      end
      misc_st_nxt = (misc_st_nxt | st_set) & ST_MASK;
   end

   // misc status register and its interrupt roll-up
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         misc_st_r        <= '0;
         int_config_error <= 1'b0;
         int_queue_error  <= 1'b0;
      end else begin
         misc_st_r        <= misc_st_nxt;
         int_config_error <= |misc_st_nxt[ST_ETERM_ERR:ST_POST_ERR];
         int_queue_error  <= |misc_st_nxt[31:ST_Q_LSB];
      end
   end

   // bus error flags from posted write errors, one bit per requester
   always_comb begin
      be_set = '0;
      // requester code 0..12 lands on bits 19..31 in the documented order
      if (slave_wr_err && write_posting_enable &&
          (slave_wr_err_req < 4'(NREQ))) begin
         be_set[BE_LSB + int'(slave_wr_err_req)] = 1'b1;
      end
      bus_err_nxt = bus_err_r;
      // clearing only touches the stored bits; a held slave irq masks them
      if (do_write && (wr_idx_r == IDX_BUS_ERR)) begin
         bus_err_nxt = bus_err_r & ~wbits;
      end
      bus_err_nxt = (bus_err_nxt | be_set) & BE_MASK;
   end

   // bus error register
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         bus_err_r <= '0;
      end else begin
         bus_err_r <= bus_err_nxt;
      end
   end

   // misc control: flush mode and one-cycle queue reset pulses
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         flush_r       <= FLUSH_AUTO;
         flush_mode    <= FLUSH_AUTO;
         auto_flush_en <= 1'b1;
         queue_reset   <= '0;
      end else begin
         queue_reset <= '0;
         if (do_write && (wr_idx_r == IDX_MISC_CTRL)) begin
            queue_reset <= wbits[CT_QRST_LSB +: NQ];
            if (wstrb_r[0]) begin
               flush_r    <= wdata_r[CT_FLUSH_LSB +: 2];
               flush_mode <= wdata_r[CT_FLUSH_LSB +: 2];
               // reserved codes are treated as no flush, the safe side
               auto_flush_en <= (wdata_r[CT_FLUSH_LSB +: 2] == FLUSH_AUTO);
            end
         end
      end
   end

   // sniffer criteria and address, reserved bits dropped on write
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         sniff_r  <= '0;
         sniffa_r <= '0;
      end else if (do_write) begin
         if (wr_idx_r == IDX_SNIFF_MATCH) begin
            sniff_r <= ((sniff_r & ~strb_mask(wstrb_r)) | wbits) & SN_MASK;
         end
         if (wr_idx_r == IDX_SNIFF_ADDR) begin
            sniffa_r <= (sniffa_r & ~strb_mask(wstrb_r)) | wbits;
         end
      end
   end

   // sniffer compare; a disabled criterion always passes
   always_comb begin
      sniff_hit = cmd_valid && sniff_r[SN_ENABLE];
      if (sniff_r[SN_SIZE_EN] && (cmd.size != sniff_r[SN_SIZE +: 4])) begin
         sniff_hit = 1'b0;
      end
      if (sniff_r[SN_RNW_EN] && (cmd.rnw != sniff_r[SN_RNW])) begin
         sniff_hit = 1'b0;
      end
      if (sniff_r[SN_MID_EN] && (cmd.mid != sniff_r[SN_MID +: 3])) begin
         sniff_hit = 1'b0;
      end
      if (sniff_r[SN_SRC_EN] && (cmd.src_slave_port != sniff_r[SN_SRC])) begin
         sniff_hit = 1'b0;
      end
      if (sniff_r[SN_FMID_EN] && (cmd.fabric_mid != sniff_r[SN_FMID +: 2])) begin
         sniff_hit = 1'b0;
      end
      if (sniff_r[SN_SSIZE_EN] && (cmd.ssize != sniff_r[SN_SSIZE +: 2])) begin
         sniff_hit = 1'b0;
      end
      if (sniff_r[SN_ADDR_EN] && (cmd.addr[31:0] != sniffa_r)) begin
         sniff_hit = 1'b0;
      end
   end

   // capture selection: a failure outranks a sniff hit in the same cycle
   always_comb begin
      cap_clr  = do_write && (wr_idx_r == IDX_CAP_STATUS);
      cap_src  = fail_valid ? fail_cmd : cmd;
      cap_take = fail_valid || sniff_hit;
      // hold mode keeps the first capture until software clears it
      if (capture_hold_when_valid && cap_st_r[CP_VLD] && !cap_clr) begin
         cap_take = 1'b0;
      end
   end

   // capture registers; a capture wins over a clear in the same cycle
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cap_hi_r <= '0;
         cap_lo_r <= '0;
         cap_st_r <= '0;
      end else if (cap_take) begin
         cap_hi_r <= '0;
         cap_hi_r[CP_UADDR +: 4]   <= cap_src.addr[35:32];
         cap_lo_r                  <= cap_src.addr[31:0];
         cap_st_r[CP_VLD]          <= 1'b1;
         cap_st_r[CP_LOCK]         <= cap_src.lock_err;
         cap_st_r[CP_SRC]          <= cap_src.src_slave_port;
         cap_st_r[CP_MID +: 3]     <= cap_src.mid;
         cap_st_r[CP_SSIZE +: 2]   <= cap_src.ssize;
         cap_st_r[CP_TYPE +: 3]    <= cap_src.xtype;
         cap_st_r[CP_RNW]          <= cap_src.rnw;
         cap_st_r[CP_SIZE +: 4]    <= cap_src.size;
         cap_st_r[CP_BE +: 16]     <= cap_src.be;
      end else if (cap_clr) begin
         cap_hi_r <= '0;
         cap_lo_r <= '0;
         cap_st_r <= '0;
      end
   end

endmodule // bms_master_status

// *** bms_master_status_checker.sv ***
// bms_master_status_checker: port assertions for the status bank.
// assumes it is bound into bms_master_status and sees only its ports.
`timescale 1ns/1ps
module bms_master_status_checker
   import bms_pkg::*;
(
   // clock, reset, bus
   input wire logic          aclk,
   input wire logic          aresetn,
   input wire logic          s_axi_bvalid,
   input wire logic          s_axi_arvalid,
   input wire logic          s_axi_arready,
   input wire logic [11:0]   s_axi_araddr,
   input wire logic          s_axi_rvalid,
   input wire logic [31:0]   s_axi_rdata,
   // configuration and events
   input wire logic          write_posting_enable,
   input wire logic          early_term_enable,
   input wire logic          cmd_valid,
   input wire bms_cmd_t      cmd,
   input wire logic          early_term_seen,
   input wire logic [NQ-1:0] queue_overflow,
   input wire logic [NQ-1:0] queue_underflow,
   input wire logic          slave_bus_irq,
   // outputs
   input wire logic [NQ-1:0] queue_reset,
   input wire logic [1:0]    flush_mode,
   input wire logic          auto_flush_en,
   input wire logic          int_config_error,
   input wire logic          int_queue_error
);
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   // read address taken this edge
   wire ar_take = s_axi_arvalid && s_axi_arready;
   a_post_err_int: assert property (
      cmd_valid && cmd.line_or_burst && !write_posting_enable |=> int_config_error)
      else $error("posting error missed");
   a_eterm_int: assert property (
      early_term_seen && !early_term_enable |=> int_config_error) else $error("eterm missed");
   a_queue_int: assert property (
      (|queue_overflow) || (|queue_underflow) |=> int_queue_error) else $error("queue missed");
   a_cfg_sticky: assert property (
      $fell(int_config_error) |-> $rose(s_axi_bvalid)) else $error("cfg flag lost");
   a_queue_sticky: assert property (
      $fell(int_queue_error) |-> $rose(s_axi_bvalid)) else $error("queue flag lost");
   a_flush_auto: assert property (
      auto_flush_en == (flush_mode == FLUSH_AUTO)) else $error("auto flush wrong");
   a_qrst_pulse: assert property (
      |queue_reset |-> $rose(s_axi_bvalid) ##1 queue_reset == '0) else $error("qrst bad");
   a_read_answer: assert property (
      ar_take |=> s_axi_rvalid) else $error("read answer late");
   a_state_zero: assert property (
      ar_take && s_axi_araddr[11:2] == IDX_SM_STATE |=> s_axi_rdata == '0)
      else $error("state reg not zero");
   a_irq_ones: assert property (
      ar_take && s_axi_araddr[11:2] == IDX_BUS_ERR && slave_bus_irq
      |=> s_axi_rdata[31:19] == '1) else $error("irq bits not set");
   // main scenarios reached
   c_qrst: cover property (|queue_reset);
   c_irq_read: cover property (slave_bus_irq && s_axi_rvalid);
   c_queue_clear: cover property ($fell(int_queue_error));
endmodule // bms_master_status_checker
bind bms_master_status bms_master_status_checker u_bms_master_status_checker (.*);

// *** bms_fabric_model.sv ***
// bms_fabric_model: behavioural master port logic and fabric slaves.
// assumes its tasks are called right after a rising edge of aclk.
`timescale 1ns/1ps
module bms_fabric_model
   import bms_pkg::*;
(
   // clock
   input  wire logic     aclk,
   // commands and failures
   output bms_cmd_t      cmd,
   output bms_cmd_t      fail_cmd,
   output logic          cmd_valid,
   output logic          fail_valid,
   // queue and slave events
   output logic          early_term_seen,
   output logic [NQ-1:0] queue_overflow,
   output logic [NQ-1:0] queue_underflow,
   output logic          slave_bus_irq,
   output logic          slave_wr_err,
   output logic [3:0]    slave_wr_err_req
);
   // quiet at time zero
   initial begin
      {cmd_valid, fail_valid, early_term_seen, slave_wr_err, slave_bus_irq} = '0;
      {queue_overflow, queue_underflow, slave_wr_err_req, cmd, fail_cmd} = '0;
   end
   // one cycle of command; afterwards the bus shows junk, not the old value
   task automatic send(input bms_cmd_t c, input logic fl);
      {cmd, fail_cmd, cmd_valid, fail_valid} <= {c, c, ~fl, fl};
      @(posedge aclk);
      {cmd, fail_cmd, cmd_valid, fail_valid} <= {~c, ~c, 2'h0};
   endtask
   // single-cycle events; requester code garbled when idle
   task automatic pulse(input logic et, we, input logic [3:0] rq, input logic [NQ-1:0] ov, uf);
      {early_term_seen, slave_wr_err, queue_overflow, queue_underflow} <= {et, we, ov, uf};
      slave_wr_err_req <= rq;
      @(posedge aclk);
      {early_term_seen, slave_wr_err, queue_overflow, queue_underflow} <= '0;
      slave_wr_err_req <= ~rq;
   endtask
   // latched slave interrupt level
   task automatic irq(input logic v);
      slave_bus_irq <= v;
      @(posedge aclk);
   endtask
endmodule // bms_fabric_model

// *** bms_master_status_tb.sv ***
// bms_master_status_tb: register tests of the master port status bank.
// assumes 50 MHz aclk and the fabric model on every event input.
`timescale 1ns/1ps
module bms_master_status_tb
   import bms_pkg::*;
();
   logic          aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic          s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
   logic          s_axi_rready, write_posting_enable, early_term_enable, cmd_valid, fail_valid;
   logic          capture_hold_when_valid, early_term_seen, slave_bus_irq, slave_wr_err;
   logic          auto_flush_en, int_config_error, int_queue_error;
   logic [11:0]   s_axi_awaddr, s_axi_araddr;
   logic [31:0]   s_axi_wdata, s_axi_rdata, rd_seen, e;
   logic [3:0]    s_axi_wstrb, slave_wr_err_req;
   logic [1:0]    s_axi_bresp, s_axi_rresp, flush_mode, resp_seen;
   logic [NQ-1:0] queue_overflow, queue_underflow, queue_reset, qr_seen;
   bms_cmd_t      cmd, fail_cmd, c;
   int            fail_count, checked;
   bms_master_status u_bms_master_status (.*);
   bms_fabric_model u_bms_fabric_model (.*);
   initial begin
      aclk = 1'b0;
      forever #10 aclk = ~aclk;
   end
   task automatic chk(input string nm, input logic [31:0] seen, exp);
      checked++;
      if (seen !== exp) begin
         fail_count++;
         $display("BAD %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   // write: address and data together, bready held high
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      {s_axi_awaddr, s_axi_wdata, s_axi_awvalid, s_axi_wvalid} <= {a, d, 2'h3};
      do begin
         @(posedge aclk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (s_axi_bvalid !== 1'b1);
      {qr_seen, resp_seen} = {queue_reset, s_axi_bresp};
   endtask
   task automatic rd(input logic [11:0] a);
      {s_axi_araddr, s_axi_arvalid} <= {a, 1'b1};
      do begin
         @(posedge aclk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (s_axi_rvalid !== 1'b1);
      {rd_seen, resp_seen} = {s_axi_rdata, s_axi_rresp};
   endtask
   task automatic rchk(input logic [11:0] a, input logic [31:0] exp);
      rd(a);
      chk($sformatf("reg %h", a), rd_seen, exp);
   endtask
   task automatic results;
      if (fail_count == 0 && checked > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   // hang guard, far beyond the few hundred cycles needed
   initial begin
      #400000;
      fail_count++;
      results();
   end
   initial begin
      {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_arvalid, capture_hold_when_valid} = '0;
      {s_axi_bready, s_axi_rready, write_posting_enable, early_term_enable} = '1;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = {56'h0, 4'hF};
      {fail_count, checked} = '0;
      repeat (5) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      for (int a = 12'h158; a <= 12'h178; a += 4) rchk(12'(a), 32'h0);
      wr(12'h004, 32'hFFFF_FFFF);
      chk("bresp", 32'(resp_seen), 32'(RESP_DECERR));
      rd(12'h000);
      chk("rresp", 32'(resp_seen), 32'(RESP_DECERR));
      // burst while posting is off, sticky until a one is written
      write_posting_enable <= 1'b0;
      c = '0;
      c.line_or_burst = 1'b1;
      u_bms_fabric_model.send(c, 1'b0);
      rchk(12'h164, 32'h1);
      chk("int_cfg", 32'(int_config_error), 32'h1);
      wr(12'h164, 32'h0);
      rchk(12'h164, 32'h1);
      wr(12'h164, 32'h1);
      chk("int_cfg", 32'(int_config_error), 32'h0);
      early_term_enable <= 1'b0;
      u_bms_fabric_model.pulse(1'b1, 1'b0, 4'h0, '0, '0);
      rchk(12'h164, 32'h2);
      chk("int_cfg", 32'(int_config_error), 32'h1);
      wr(12'h164, 32'h2);
      // queue flags fill in pairs, in queue order
      e = '0;
      for (int q = 0; q < NQ; q++) begin
         u_bms_fabric_model.pulse(1'b0, 1'b0, 4'h0, 7'(1 << q), '0);
         e[18 + 2 * q] = 1'b1;
         rchk(12'h164, e);
         u_bms_fabric_model.pulse(1'b0, 1'b0, 4'h0, '0, 7'(1 << q));
         e[19 + 2 * q] = 1'b1;
         rchk(12'h164, e);
      end
      chk("int_q", 32'(int_queue_error), 32'h1);
      wr(12'h164, 32'hFFFF_FFFF);
      rchk(12'h164, 32'h0);
      chk("int_q", 32'(int_queue_error), 32'h0);
      // posted write errors, one requester bit each
      write_posting_enable <= 1'b1;
      for (int i = 0; i < 13; i++) begin
         u_bms_fabric_model.pulse(1'b0, 1'b1, 4'(i), '0, '0);
         rchk(12'h168, 32'h1 << (19 + i));
         wr(12'h168, 32'h1 << (19 + i));
      end
      rchk(12'h168, 32'h0);
      u_bms_fabric_model.irq(1'b1);
      wr(12'h168, 32'hFFFF_FFFF);
      rchk(12'h168, 32'hFFF8_0000);
      u_bms_fabric_model.irq(1'b0);
      rchk(12'h168, 32'h0);
      // flush codes and queue resets; write-only and reserved bits read zero
      for (int i = 0; i < NQ; i++) begin
         wr(12'h170, 32'({i[1:0], 1'b0}) | (32'h1 << (25 + i)) | 32'h9);
         chk("qrst", 32'(qr_seen), 32'(1 << i));
         rchk(12'h170, 32'({i[1:0], 1'b0}));
         chk("auto", 32'(auto_flush_en), 32'(i[1:0] == 2'h0));
         chk("flush", 32'(flush_mode), 32'(i[1:0]));
      end
      // sniffer: gate, criteria, address, capture
      wr(12'h174, 32'hFFFF_FFFF);
      rchk(12'h174, SN_MASK);
      wr(12'h178, 32'h1234_5678);
      rchk(12'h178, 32'h1234_5678);
      wr(12'h174, 32'h8200_0030);
      c = '0;
      {c.addr, c.size, c.rnw} = {36'hA_1234_5678, 4'h3, 1'b1};
      u_bms_fabric_model.send(c, 1'b0);
      rchk(12'h160, 32'h0);
      wr(12'h174, 32'h8200_0031);
      c.size = 4'h2;
      u_bms_fabric_model.send(c, 1'b0);
      rchk(12'h160, 32'h0);
      {c.size, c.addr} = {4'h3, 36'hA_1234_5679};
      u_bms_fabric_model.send(c, 1'b0);
      rchk(12'h160, 32'h0);
      c.addr = 36'hA_1234_5678;
      u_bms_fabric_model.send(c, 1'b0);
      rchk(12'h160, 32'h0000_3801);
      rchk(12'h15C, 32'h1234_5678);
      rchk(12'h158, 32'hA000_0000);
      wr(12'h160, 32'h0);
      rchk(12'h160, 32'h0);
      u_bms_fabric_model.send('0, 1'b1);
      rchk(12'h160, 32'h1);
      capture_hold_when_valid <= 1'b1;
      u_bms_fabric_model.send(c, 1'b1);
      rchk(12'h160, 32'h1);
      results();
   end
endmodule // bms_master_status_tb
